// *** program_erase_suspend_sequencer.sv ***
/*
 Host controller that drives a parallel non-volatile memory through its pins:
 buffered and preset programming, block erase, suspend, resume, status polling.
 Assumes one 50 MHz mclk, synchronous reset, and a user that offers one order
 at a time and streams program words on the write data handshake.
*/
`timescale 1ns/1ps
`include "flash_host_map.svh"

// How it works
// - Preset programming reuses the buffered program code
// - Host writes read array before array reads when not already in array mode
// - Host holds write guard steady while suspended
// - Erase is setup then confirm in block
module program_erase_suspend_sequencer (
   input  wire logic                 mclk,
   input  wire logic                 sys_rst,
   input  wire logic                 op_valid,
   output logic                      op_ready,
   input  wire flash_host_pkg::op_t  op_code,
   input  wire logic [`ADDR_W-1:0]   op_addr,
   input  wire logic [`COUNT_W-1:0]  op_count,
   input  wire logic                 wr_data_valid,
   output logic                      wr_data_ready,
   input  wire logic [`DATA_W-1:0]   wr_data,
   input  wire logic                 wp_req,
   output logic                      op_done,
   output logic                      op_refused,
   output logic [7:0]                status,
   output logic [`DATA_W-1:0]        rd_data,
   output logic                      prog_suspended,
   output logic                      erase_suspended,
   output logic [`ADDR_W-1:0]        mem_addr,
   output logic                      mem_ce_n,
   output logic                      mem_oe_n,
   output logic                      mem_we_n,
   output logic                      mem_rst_n,
   output logic                      mem_wp_n,
   output logic [`DATA_W-1:0]        dq_out,
   output logic                      dq_oe_n,
   input  wire logic [`DATA_W-1:0]   dq_in
);
   bus_cycle_if cyc ();

   flash_host_pkg::seq_state_t state;
   flash_host_pkg::op_t        op;
   logic [7:0]                 cmd;
   logic [`ADDR_W-1:0]         base_addr;
   logic [`ADDR_W-1:0]         cur_addr;
   logic [`ADDR_W-1:0]         erase_block;
   logic [`COUNT_W-1:0]        words;
   logic [`COUNT_W-1:0]        words_left;
   logic [3:0]                 rst_cnt;
   logic                       issued;
   logic                       array_mode;
   logic                       step_write;
   logic [`ADDR_W-1:0]         step_addr;
   logic [`DATA_W-1:0]         step_data;
   logic [7:0]                 last_cmd;

   bus_cycle_engine u_engine (
      .mclk     (mclk),
      .sys_rst  (sys_rst),
      .cyc      (cyc),
      .mem_addr (mem_addr),
      .mem_ce_n (mem_ce_n),
      .mem_oe_n (mem_oe_n),
      .mem_we_n (mem_we_n),
      .dq_out   (dq_out),
      .dq_oe_n  (dq_oe_n),
      .dq_in    (dq_in)
   );

   wire in_susp     = prog_suspended | erase_suspended;
   wire same_block  = (op_addr[`ADDR_W-1:`BLOCK_LSB] == erase_block[`ADDR_W-1:`BLOCK_LSB]);
   wire is_prog_op  = (op_code == flash_host_pkg::OP_BUF_PROG) | (op_code == flash_host_pkg::OP_PRESET_PROG);
   wire is_read_cmd = (op_code == flash_host_pkg::OP_READ_ARRAY) | (op_code == flash_host_pkg::OP_READ_STATUS);
   wire ok_prog_susp = is_read_cmd | (op_code == flash_host_pkg::OP_RESUME) |
                       (op_code == flash_host_pkg::OP_RESET) | (op_code == flash_host_pkg::OP_READ);
   wire ok_erase_susp = ok_prog_susp | (op_code == flash_host_pkg::OP_CLEAR_STATUS) |
                        (op_code == flash_host_pkg::OP_SUSPEND) | (is_prog_op & !same_block) |
                        ((op_code == flash_host_pkg::OP_READ) & !same_block);
   wire op_allowed = prog_suspended ? ok_prog_susp :
                     erase_suspended ? (ok_erase_susp & !((op_code == flash_host_pkg::OP_READ) & same_block)) :
                     1'b1;
   wire op_take   = op_valid & op_ready;
   wire step_bus  = (state != flash_host_pkg::S_IDLE) & (state != flash_host_pkg::S_RST) &
                    (state != flash_host_pkg::S_FIN);
   wire need_data = (state == flash_host_pkg::S_BP_DATA);
   wire ready_now = cyc.rdata[`FLAG_READY];

   assign op_ready      = (state == flash_host_pkg::S_IDLE);
   assign wr_data_ready = need_data & !issued & cyc.ready;
   assign cyc.req       = step_bus & !issued & cyc.ready & (!need_data | wr_data_valid);
   assign cyc.is_write  = step_write;
   assign cyc.addr      = step_addr;
   assign cyc.wdata     = step_data;

   // Bus step for each state
   always_comb begin
      step_write = 1'b1;
      step_addr  = base_addr;
      step_data  = {8'h00, cmd};
      case (state)
         flash_host_pkg::S_BP_SETUP: step_data = {8'h00, `CMD_BUF_PROG};
         flash_host_pkg::S_BP_WAIT:  step_write = 1'b0;
         flash_host_pkg::S_BP_COUNT: step_data = {{(`DATA_W-`COUNT_W){1'b0}}, words};
         flash_host_pkg::S_BP_DATA: begin
            step_addr = cur_addr;
            step_data = wr_data;
         end
         flash_host_pkg::S_BP_CONF:  step_data = {8'h00, `CMD_CONFIRM};
         flash_host_pkg::S_ER_SETUP: step_data = {8'h00, `CMD_ERASE_SETUP};
         flash_host_pkg::S_ER_CONF:  step_data = {8'h00, `CMD_CONFIRM};
         flash_host_pkg::S_POLL:     step_write = 1'b0;
         flash_host_pkg::S_RA:       step_data = {8'h00, `CMD_READ_ARRAY};
         flash_host_pkg::S_RD:       step_write = 1'b0;
         default:                    step_write = 1'b1;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         mem_wp_n <= 1'b0;
      end else if (!in_susp) begin
         mem_wp_n <= wp_req;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         issued <= 1'b0;
      end else if (cyc.req) begin
         issued <= 1'b1;
      end else if (cyc.done) begin
         issued <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         last_cmd <= 8'h00;
      end else if (cyc.req & cyc.is_write) begin
         last_cmd <= cyc.wdata[7:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state           <= flash_host_pkg::S_IDLE;
         op              <= flash_host_pkg::OP_READ_ARRAY;
         cmd             <= 8'h00;
         base_addr       <= '0;
         cur_addr        <= '0;
         erase_block     <= '0;
         words           <= '0;
         words_left      <= '0;
         rst_cnt         <= 4'h0;
         array_mode      <= 1'b1;
         status          <= 8'h00;
         rd_data         <= '0;
         prog_suspended  <= 1'b0;
         erase_suspended <= 1'b0;
         mem_rst_n       <= 1'b1;
         op_done         <= 1'b0;
         op_refused      <= 1'b0;
      end else begin
         op_done    <= 1'b0;
         op_refused <= 1'b0;
         case (state)
            flash_host_pkg::S_IDLE: begin
               if (op_take & !op_allowed) begin
                  op_refused <= 1'b1;
               end else if (op_take) begin
                  op         <= op_code;
                  base_addr  <= op_addr;
                  cur_addr   <= op_addr;
                  words      <= op_count;
                  words_left <= op_count;
                  case (op_code)
                     flash_host_pkg::OP_BUF_PROG,
                     flash_host_pkg::OP_PRESET_PROG: state <= flash_host_pkg::S_BP_SETUP;
                     flash_host_pkg::OP_ERASE: begin
                        erase_block <= op_addr;
                        state       <= flash_host_pkg::S_ER_SETUP;
                     end
                     flash_host_pkg::OP_SUSPEND: begin
                        cmd   <= `CMD_SUSPEND;
                        state <= flash_host_pkg::S_ONE;
                     end
                     flash_host_pkg::OP_RESUME: begin
                        cmd   <= `CMD_CONFIRM;
                        state <= flash_host_pkg::S_ONE;
                     end
                     flash_host_pkg::OP_READ_ARRAY: begin
                        cmd   <= `CMD_READ_ARRAY;
                        state <= flash_host_pkg::S_ONE;
                     end
                     flash_host_pkg::OP_READ_STATUS: begin
                        cmd   <= `CMD_READ_STATUS;
                        state <= flash_host_pkg::S_ONE;
                     end
                     flash_host_pkg::OP_CLEAR_STATUS: begin
                        cmd   <= `CMD_CLEAR_STATUS;
                        state <= flash_host_pkg::S_ONE;
                     end
                     flash_host_pkg::OP_READ: state <= array_mode ? flash_host_pkg::S_RD : flash_host_pkg::S_RA;
                     flash_host_pkg::OP_RESET: begin
                        mem_rst_n <= 1'b0;
                        rst_cnt   <= 4'(`RST_CYC - 1);
                        state     <= flash_host_pkg::S_RST;
                     end
                     default: op_refused <= 1'b1;
                  endcase
               end
            end
            flash_host_pkg::S_ONE: begin
               if (cyc.done) begin
                  array_mode <= (cmd == `CMD_READ_ARRAY);
                  state      <= ((op == flash_host_pkg::OP_SUSPEND) | (op == flash_host_pkg::OP_RESUME)) ?
                                flash_host_pkg::S_POLL : flash_host_pkg::S_FIN;
               end
            end
            flash_host_pkg::S_BP_SETUP: begin
               array_mode <= 1'b0;
               if (cyc.done) begin
                  state <= flash_host_pkg::S_BP_WAIT;
               end
            end
            flash_host_pkg::S_BP_WAIT: begin
               if (cyc.done & ready_now) begin
                  state <= flash_host_pkg::S_BP_COUNT;
               end
            end
            flash_host_pkg::S_BP_COUNT: begin
               if (cyc.done) begin
                  state <= flash_host_pkg::S_BP_DATA;
               end
            end
            flash_host_pkg::S_BP_DATA: begin
               if (cyc.done) begin
                  cur_addr   <= cur_addr + 1'b1;
                  words_left <= words_left - 1'b1;
                  if (words_left == '0) begin
                     state <= flash_host_pkg::S_BP_CONF;
                  end
               end
            end
            flash_host_pkg::S_BP_CONF: begin
               if (cyc.done) begin
                  state <= flash_host_pkg::S_POLL;
               end
            end
            flash_host_pkg::S_ER_SETUP: begin
               array_mode <= 1'b0;
               if (cyc.done) begin
                  state <= flash_host_pkg::S_ER_CONF;
               end
            end
            flash_host_pkg::S_ER_CONF: begin
               if (cyc.done) begin
                  state <= flash_host_pkg::S_POLL;
               end
            end
            flash_host_pkg::S_POLL: begin
               if (cyc.done & ready_now) begin
                  status          <= cyc.rdata[7:0];
                  prog_suspended  <= cyc.rdata[`FLAG_PROG_SUSP];
                  erase_suspended <= cyc.rdata[`FLAG_ERASE_SUSP];
                  state           <= flash_host_pkg::S_FIN;
               end
            end
            flash_host_pkg::S_RA: begin
               if (cyc.done) begin
                  array_mode <= 1'b1;
                  state      <= flash_host_pkg::S_RD;
               end
            end
            flash_host_pkg::S_RD: begin
               if (cyc.done) begin
                  rd_data <= cyc.rdata;
                  state   <= flash_host_pkg::S_FIN;
               end
            end
            flash_host_pkg::S_RST: begin
               rst_cnt <= rst_cnt - 4'h1;
               if (rst_cnt == 4'h0) begin
                  mem_rst_n       <= 1'b1;
                  prog_suspended  <= 1'b0;
                  erase_suspended <= 1'b0;
                  array_mode      <= 1'b1;
                  state           <= flash_host_pkg::S_FIN;
               end
            end
            flash_host_pkg::S_FIN: begin
               op_done <= 1'b1;
               state   <= flash_host_pkg::S_IDLE;
            end
            default: state <= flash_host_pkg::S_IDLE;
         endcase
      end
   end

   AST_WP_STEADY: assert property (@(posedge mclk) disable iff (sys_rst)
      (prog_suspended | erase_suspended) & $past(prog_suspended | erase_suspended) |-> $stable(mem_wp_n))
      else $error("write guard changed while suspended");

   AST_ERASE_PAIR: assert property (@(posedge mclk) disable iff (sys_rst)
      cyc.req & (state == flash_host_pkg::S_ER_CONF) |-> (cyc.wdata[7:0] == `CMD_CONFIRM) &
      (last_cmd == `CMD_ERASE_SETUP) & (cyc.addr == base_addr))
      else $error("erase confirm not preceded by setup");

   AST_PRESET_CODE: assert property (@(posedge mclk) disable iff (sys_rst)
      cyc.req & (state == flash_host_pkg::S_BP_SETUP) |-> cyc.is_write & (cyc.wdata[7:0] == `CMD_BUF_PROG))
      else $error("buffered setup code wrong");

   AST_ARRAY_BEFORE_READ: assert property (@(posedge mclk) disable iff (sys_rst)
      cyc.req & (state == flash_host_pkg::S_RD) |-> array_mode & !cyc.is_write)
      else $error("array read without read array command");

   AST_REFUSE_KEEPS: assert property (@(posedge mclk) disable iff (sys_rst)
      op_take & !op_allowed |=> op_refused & (state == flash_host_pkg::S_IDLE) &
      $stable(prog_suspended) & $stable(erase_suspended))
      else $error("refused order disturbed state");

   AST_NO_ERASE_IN_SUSP: assert property (@(posedge mclk) disable iff (sys_rst)
      op_take & erase_suspended & (op_code == flash_host_pkg::OP_ERASE) |=> op_refused)
      else $error("second erase accepted in erase suspend");

   AST_RESET_WIDTH: assert property (@(posedge mclk) disable iff (sys_rst)
      $fell(mem_rst_n) |-> !mem_rst_n [*5] ##1 mem_rst_n)
      else $error("device reset pulse width wrong");

   AST_CONFIRM_AFTER_DATA: assert property (@(posedge mclk) disable iff (sys_rst)
      (state == flash_host_pkg::S_BP_DATA) & cyc.done & (words_left == '0) |=> (state == flash_host_pkg::S_BP_CONF))
      else $error("confirm not issued after last word");

endmodule : program_erase_suspend_sequencer

// *** flash_host_map.svh ***
/*
 Command codes, status flag positions, bus widths and bus timing counts for the
 host side of a parallel non-volatile memory. Assumes a 50 MHz mclk.
*/
`ifndef FLASH_HOST_MAP_SVH
`define FLASH_HOST_MAP_SVH

`define ADDR_W            23
`define DATA_W            16
`define BLOCK_LSB         16
`define COUNT_W           5

`define CMD_BUF_PROG      8'he8
`define CMD_CONFIRM       8'hd0
`define CMD_ERASE_SETUP   8'h20
`define CMD_SUSPEND       8'hb0
`define CMD_READ_ARRAY    8'hff
`define CMD_READ_STATUS   8'h70
`define CMD_CLEAR_STATUS  8'h50

`define FLAG_READY        7
`define FLAG_ERASE_SUSP   6
`define FLAG_ERASE_FAIL   5
`define FLAG_PROG_FAIL    4
`define FLAG_SUPPLY_ERR   3
`define FLAG_PROG_SUSP    2
`define FLAG_LOCKED       1

`define CLK_NS            20
`define T_WE_NS           60
`define T_ACC_NS          140
`define T_GAP_NS          40
`define T_RST_NS          100
`define SYNC_CYC          2
`define WE_CYC            ((`T_WE_NS + `CLK_NS - 1) / `CLK_NS)
`define ACC_CYC           ((`T_ACC_NS + `CLK_NS - 1) / `CLK_NS + `SYNC_CYC)
`define GAP_CYC           ((`T_GAP_NS + `CLK_NS - 1) / `CLK_NS)
`define RST_CYC           ((`T_RST_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// *** flash_host_pkg.sv ***
/*
 Types shared by the sequencer and the bus cycle engine.
 Assumes flash_host_map.svh for all numeric constants.
*/
package flash_host_pkg;

   typedef enum logic [3:0] {
      OP_BUF_PROG, OP_PRESET_PROG, OP_ERASE, OP_SUSPEND, OP_RESUME,
      OP_READ_ARRAY, OP_READ_STATUS, OP_CLEAR_STATUS, OP_READ, OP_RESET
   } op_t;

   typedef enum logic [3:0] {
      S_IDLE, S_ONE, S_POLL, S_BP_SETUP, S_BP_WAIT, S_BP_COUNT, S_BP_DATA,
      S_BP_CONF, S_ER_SETUP, S_ER_CONF, S_RA, S_RD, S_RST, S_FIN
   } seq_state_t;

   typedef enum logic [1:0] {
      E_IDLE, E_WR, E_RD, E_GAP
   } eng_state_t;

endpackage : flash_host_pkg

// *** bus_cycle_if.sv ***
/*
 Request and answer between the sequencer and the bus cycle engine.
 Assumes both ends run on mclk.
*/
`timescale 1ns/1ps
`include "flash_host_map.svh"

interface bus_cycle_if;
   logic               req;
   logic               is_write;
   logic [`ADDR_W-1:0] addr;
   logic [`DATA_W-1:0] wdata;
   logic               ready;
   logic               done;
   logic [`DATA_W-1:0] rdata;

   modport seq (output req, is_write, addr, wdata, input ready, done, rdata);
   modport eng (input req, is_write, addr, wdata, output ready, done, rdata);
endinterface : bus_cycle_if

// *** bus_cycle_engine.sv ***
/*
 Runs one asynchronous write or read cycle on the memory pins per request.
 Assumes dq_in comes from the pin and is synchronised here; each cycle ends with
 chip select and output gate released, so every status read is a fresh toggle.
*/
`timescale 1ns/1ps
`include "flash_host_map.svh"

module bus_cycle_engine (
   input  wire logic               mclk,
   input  wire logic               sys_rst,
   bus_cycle_if.eng                cyc,
   output logic [`ADDR_W-1:0]      mem_addr,
   output logic                    mem_ce_n,
   output logic                    mem_oe_n,
   output logic                    mem_we_n,
   output logic [`DATA_W-1:0]      dq_out,
   output logic                    dq_oe_n,
   input  wire logic [`DATA_W-1:0] dq_in
);
   flash_host_pkg::eng_state_t state;
   logic [3:0]                 cnt;
   logic [`DATA_W-1:0]         dq_meta;
   logic [`DATA_W-1:0]         dq_sync;
   wire                        cnt_zero = (cnt == 4'h0);

   assign cyc.ready = (state == flash_host_pkg::E_IDLE);

   always_ff @(posedge mclk) begin
      dq_meta <= dq_in;
      dq_sync <= dq_meta;
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state     <= flash_host_pkg::E_IDLE;
         cnt       <= 4'h0;
         mem_addr  <= '0;
         mem_ce_n  <= 1'b1;
         mem_oe_n  <= 1'b1;
         mem_we_n  <= 1'b1;
         dq_out    <= '0;
         dq_oe_n   <= 1'b1;
         cyc.done  <= 1'b0;
         cyc.rdata <= '0;
      end else begin
         cyc.done <= 1'b0;
         case (state)
            flash_host_pkg::E_IDLE: begin
               if (cyc.req) begin
                  mem_addr <= cyc.addr;
                  mem_ce_n <= 1'b0;
                  if (cyc.is_write) begin
                     dq_out   <= cyc.wdata;
                     dq_oe_n  <= 1'b0;
                     mem_we_n <= 1'b0;
                     cnt      <= 4'(`WE_CYC - 1);
                     state    <= flash_host_pkg::E_WR;
                  end else begin
                     mem_oe_n <= 1'b0;
                     cnt      <= 4'(`ACC_CYC - 1);
                     state    <= flash_host_pkg::E_RD;
                  end
               end
            end
            flash_host_pkg::E_WR: begin
               cnt <= cnt - 4'h1;
               if (cnt_zero) begin
                  mem_we_n <= 1'b1;
                  mem_ce_n <= 1'b1;
                  cnt      <= 4'(`GAP_CYC - 1);
                  state    <= flash_host_pkg::E_GAP;
               end
            end
            flash_host_pkg::E_RD: begin
               cnt <= cnt - 4'h1;
               if (cnt_zero) begin
                  cyc.rdata <= dq_sync;
                  mem_oe_n  <= 1'b1;
                  mem_ce_n  <= 1'b1;
                  cnt       <= 4'(`GAP_CYC - 1);
                  state     <= flash_host_pkg::E_GAP;
               end
            end
            flash_host_pkg::E_GAP: begin
               cnt <= cnt - 4'h1;
               if (cnt_zero) begin
                  dq_oe_n  <= 1'b1;
                  cyc.done <= 1'b1;
                  state    <= flash_host_pkg::E_IDLE;
               end
            end
            default: state <= flash_host_pkg::E_IDLE;
         endcase
      end
   end
endmodule : bus_cycle_engine

// *** flash_dev_model.sv ***
/* Behavioural memory device at the pins: status, suspend, resume.
 Assumes one we_n pulse per write and one oe_n pulse per read. */
`timescale 1ns/1ps
module flash_dev_model (
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic        rst_n,
   input  wire logic [22:0] a,
   input  wire logic [15:0] d,
   output logic [15:0]      q
);
   logic [6:1]  sr = 6'h00;
   logic        arr = 1'b1;
   logic        er = 1'b0;
   int          rdn = 0;
   int          tgt = 0;
   logic [15:0] v;
   assign v = arr ? (a[15:0] ^ 16'ha5a5) : {8'h00, rdn >= tgt, sr, 1'b0};
   assign q = (!ce_n && !oe_n) ? v : ~v;
   always @(posedge oe_n) rdn <= rdn + 1;
   always @(posedge we_n or negedge rst_n) begin
      if (!rst_n) begin
         sr <= 6'h00;
         arr <= 1'b1;
         er <= 1'b0;
         tgt <= rdn;
      end else begin
         arr <= d[7:0] == 8'hff;
         case (d[7:0])
            8'h20: er <= 1'b1;
            8'he8: begin
               er <= 1'b0;
               tgt <= rdn;
            end
            8'hd0: begin
               sr[6] <= 1'b0;
               sr[2] <= 1'b0;
               tgt <= rdn + 3;
            end
            8'hb0: sr[er ? 6 : 2] <= 1'b1;
            8'h50: sr[5:1] <= 5'h00;
            default: ;
         endcase
      end
   end
endmodule : flash_dev_model

// *** tb_program_erase_suspend_sequencer.sv ***
/* Self-checking bench for the suspend sequencer against a device model.
 Assumes flash_host_map.svh and flash_host_pkg are compiled first. */
`timescale 1ns/1ps
`include "flash_host_map.svh"
module tb_program_erase_suspend_sequencer;
   logic                mclk, sys_rst, op_valid, op_ready, wr_data_valid, wr_data_ready, wp_req, op_done;
   logic                op_refused, prog_suspended, erase_suspended, mem_ce_n, mem_oe_n, mem_we_n;
   logic                mem_rst_n, mem_wp_n, dq_oe_n;
   flash_host_pkg::op_t op_code;
   logic [`ADDR_W-1:0]  op_addr, mem_addr;
   logic [`COUNT_W-1:0] op_count;
   logic [`DATA_W-1:0]  wr_data, rd_data, dq_out, dq_in;
   logic [7:0]          status;
   int                  n_fail, cmp_count;
   program_erase_suspend_sequencer program_erase_suspend_sequencer_i (.mclk, .sys_rst, .op_valid, .op_ready,
      .op_code, .op_addr, .op_count, .wr_data_valid, .wr_data_ready, .wr_data, .wp_req, .op_done, .op_refused,
      .status, .rd_data, .prog_suspended, .erase_suspended, .mem_addr, .mem_ce_n, .mem_oe_n, .mem_we_n,
      .mem_rst_n, .mem_wp_n, .dq_out, .dq_oe_n, .dq_in);
   flash_dev_model flash_dev_model_i (.ce_n(mem_ce_n), .oe_n(mem_oe_n), .we_n(mem_we_n), .rst_n(mem_rst_n),
      .a(mem_addr), .d(dq_out), .q(dq_in));
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic test_done();
      if (n_fail == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : test_done
   task automatic do_op(input flash_host_pkg::op_t c, input logic [22:0] ad, input logic rf);
      int k;
      op_code <= c;
      op_addr <= ad;
      op_valid <= 1'b1;
      @(posedge mclk);
      op_valid <= 1'b0;
      k = 0;
      do begin
         @(negedge mclk);
         k++;
      end while (op_done !== 1'b1 && op_refused !== 1'b1 && k < 2000);
      chk("answer", op_done | op_refused, 1'b1);
      chk("refused", op_refused, rf);
      @(posedge mclk);
   endtask : do_op
   // Data words advance on each handshake
   always @(posedge mclk) if (wr_data_valid && wr_data_ready) wr_data <= wr_data + 16'h0001;
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   initial begin
      #(20 * 20000);
      n_fail++;
      test_done();
   end
   initial begin
      sys_rst = 1'b1;
      op_valid = 1'b0;
      op_code = flash_host_pkg::OP_READ;
      op_addr = 23'h000000;
      op_count = 5'h01;
      wr_data_valid = 1'b1;
      wr_data = 16'h1200;
      wp_req = 1'b0;
      repeat (8) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      do_op(flash_host_pkg::OP_PRESET_PROG, 23'h010000, 1'b0);
      chk("status", status, 16'h0080);
      do_op(flash_host_pkg::OP_BUF_PROG, 23'h010040, 1'b0);
      do_op(flash_host_pkg::OP_SUSPEND, 23'h7fffff, 1'b0);
      chk("psusp", {status, prog_suspended}, {8'h84, 1'b1});
      wp_req <= 1'b1;
      do_op(flash_host_pkg::OP_CLEAR_STATUS, 23'h000000, 1'b1);
      do_op(flash_host_pkg::OP_ERASE, 23'h020000, 1'b1);
      do_op(flash_host_pkg::OP_READ, 23'h010004, 1'b0);
      chk("rdata", rd_data, 16'ha5a1);
      chk("wp", mem_wp_n, 1'b0);
      do_op(flash_host_pkg::OP_RESUME, 23'h000000, 1'b0);
      chk("resume", {status, prog_suspended}, {8'h80, 1'b0});
      do_op(flash_host_pkg::OP_SUSPEND, 23'h000000, 1'b0);
      do_op(flash_host_pkg::OP_RESET, 23'h000000, 1'b0);
      chk("rst", prog_suspended, 1'b0);
      do_op(flash_host_pkg::OP_ERASE, 23'h020000, 1'b0);
      do_op(flash_host_pkg::OP_SUSPEND, 23'h000000, 1'b0);
      chk("esusp", {status, erase_suspended}, {8'hc0, 1'b1});
      do_op(flash_host_pkg::OP_READ, 23'h020010, 1'b1);
      do_op(flash_host_pkg::OP_ERASE, 23'h030000, 1'b1);
      do_op(flash_host_pkg::OP_CLEAR_STATUS, 23'h000000, 1'b0);
      do_op(flash_host_pkg::OP_READ, 23'h030004, 1'b0);
      chk("erd", rd_data, 16'ha5a1);
      do_op(flash_host_pkg::OP_RESUME, 23'h000000, 1'b0);
      chk("eres", {status, erase_suspended}, {8'h80, 1'b0});
      chk("words", wr_data, 16'h1204);
      chk("wp_end", mem_wp_n, 1'b1);
      chk("pins", {mem_ce_n, mem_oe_n, mem_we_n, mem_rst_n, dq_oe_n, op_ready}, 16'h003f);
      test_done();
   end
endmodule : tb_program_erase_suspend_sequencer
